// >>> verilog/bts_pkg.sv
// constants and carrier types for the burst-of-two sram port
// assumes one link clock pair with the complement edge taken as kClk fall

package bts_pkg;

    // ********************************************************
    // sizes
    // ********************************************************
    localparam int ADDR_W  = 4;
    localparam int DEPTH   = 16;
    localparam int LANE_W  = 9;
    localparam int LANES   = 4;
    localparam int DATA_W  = LANE_W * LANES;
    localparam int NARROW_LANES = 2;

    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
    localparam logic [LANES-1:0]  BWS_RST  = 4'hf;
    localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;

    typedef struct packed {
        logic              loadN;
        logic              readSel;
        logic [ADDR_W-1:0] addr;
    } bts_cmd_t;

    typedef enum logic [1:0] {
        BTS_IDLE  = 2'b00,
        BTS_READ  = 2'b01,
        BTS_WRITE = 2'b10
    } bts_op_t;

endpackage

// >>> verilog/bts_sync.sv
// two-flop level synchroniser
// assumes the destination reset is synchronous to dstClk

`timescale 1ns/1ps

module bts_sync #(
    parameter int W = 1
) (
    input  wire logic         dstClk,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);

    // first stage feeds only the second stage
    logic [W-1:0] meta_r;

    always_ff @(posedge dstClk)
    begin
        meta_r  <= asyncIn;
        syncOut <= meta_r;
    end

endmodule

// >>> verilog/bts_sram_port.sv
// device end of a burst-of-two ddr sram port with a flip-flop array
// assumes kClk from the controller, its complement taken as kClk fall,
// and the output clock pair phase aligned with kClk
// What this block does
// - write: load low, select low; beat0 at next rise, beat1 next fall
// - read: word0 on fall of t+1, word1 on rise of t+2
// - start address latched; second word uses address with lsb inverted
// - after reset deselected, data outputs released until a read
// - data captured on both clock edges; outputs launched on both edges
// - 18-bit mode: select0 gates bits 8:0, select1 gates bits 17:9
// - 36-bit mode: four selects gate four nine-bit lanes
// - all selects high on a beat writes nothing for that beat
// - selects sampled separately for each beat
// - after reads end, outputs release after next rise
// - single clock strap from both output clock pins high at start

`timescale 1ns/1ps

module bts_sram_port #(
    parameter bit WIDE36 = 1'b1
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    input  wire logic                      kClk,
    input  wire logic                      load_strobe_n,
    input  wire logic                      readNotWrite,
    input  wire logic [bts_pkg::ADDR_W-1:0] addrIn,
    input  wire logic [bts_pkg::DATA_W-1:0] dqIn,
    input  wire logic [bts_pkg::LANES-1:0]  byte_write_select_n,
    input  wire logic                      outClkPosPin,
    input  wire logic                      outClkNegPin,
    output logic      [bts_pkg::DATA_W-1:0] dqOut,
    output logic                           dqOe,
    output logic                           singleClkMode,
    output logic                           linkBusy,
    output logic                           writeDoneStb
);

    // ********************************************************
    // functions
    // ********************************************************
    function automatic logic [bts_pkg::DATA_W-1:0] mergeLanes(
        input logic [bts_pkg::DATA_W-1:0] oldW,
        input logic [bts_pkg::DATA_W-1:0] newW,
        input logic [bts_pkg::LANES-1:0]  selN
    );
        logic [bts_pkg::DATA_W-1:0] res;
        res = oldW;
        for (int i = 0; i < bts_pkg::LANES; i++)
        begin
            // narrow part has only two lanes
            if (!selN[i] && (WIDE36 || i < bts_pkg::NARROW_LANES))
                res[i*bts_pkg::LANE_W +: bts_pkg::LANE_W] =
                    newW[i*bts_pkg::LANE_W +: bts_pkg::LANE_W];
        end
        return res; // all selects high leaves the word
    endfunction

    // ********************************************************
    // link reset and strap
    // ********************************************************
    logic       linkRstN;
    logic [1:0] strapSync;
    bts_sync #(.W(1)) uRstSync (
        .dstClk  (kClk),
        .asyncIn (rst_n),
        .syncOut (linkRstN)
    );
    bts_sync #(.W(2)) uStrapSync (
        .dstClk  (kClk),
        .asyncIn ({outClkPosPin, outClkNegPin}),
        .syncOut (strapSync)
    );

    bts_pkg::bts_cmd_t cmd;
    assign cmd = '{loadN: load_strobe_n, readSel: readNotWrite,
                   addr: addrIn};

    // ********************************************************
    // rising-edge link state
    // ********************************************************
    logic [bts_pkg::DATA_W-1:0] mem_r [bts_pkg::DEPTH];
    logic [bts_pkg::DATA_W-1:0] mem_nxt [bts_pkg::DEPTH];
    bts_pkg::bts_op_t           op_r, op_nxt;
    logic [bts_pkg::ADDR_W-1:0] opAddr_r, opAddr_nxt;
    logic [bts_pkg::ADDR_W-1:0] wbAddr_r, wbAddr_nxt;
    logic                       beat0Taken_r, beat0Taken_nxt;
    logic [bts_pkg::DATA_W-1:0] beat0Data_r, beat0Data_nxt;
    logic [bts_pkg::LANES-1:0]  beat0Bws_r, beat0Bws_nxt;
    logic                       rdLive_r, rdLive_nxt;
    logic [bts_pkg::DATA_W-1:0] rdWord0_r, rdWord0_nxt;
    logic [bts_pkg::DATA_W-1:0] rdWord1_r, rdWord1_nxt;
    logic [bts_pkg::DATA_W-1:0] posData_r, posData_nxt;
    logic                       posOe_r, posOe_nxt;
    logic                       strapDone_r, strapDone_nxt;
    logic                       singleClk_r, singleClk_nxt;
    logic                       wrTgl_r, wrTgl_nxt;
    logic                       busyLink_r, busyLink_nxt;
    logic [bts_pkg::DATA_W-1:0] beat1Data_r;
    logic [bts_pkg::LANES-1:0]  beat1Bws_r;

    always_comb
    begin
        mem_nxt        = mem_r;
        op_nxt         = bts_pkg::BTS_IDLE;
        opAddr_nxt     = opAddr_r;
        wbAddr_nxt     = wbAddr_r;
        beat0Taken_nxt = 1'b0;
        beat0Data_nxt  = beat0Data_r;
        beat0Bws_nxt   = beat0Bws_r;
        rdLive_nxt     = 1'b0;
        rdWord0_nxt    = rdWord0_r;
        rdWord1_nxt    = rdWord1_r;
        strapDone_nxt  = 1'b1;
        singleClk_nxt  = strapDone_r ? singleClk_r : (&strapSync);
        wrTgl_nxt      = wrTgl_r;
        // commit both beats one edge after the falling beat
        if (beat0Taken_r)
        begin
            mem_nxt[wbAddr_r] = mergeLanes(mem_r[wbAddr_r], beat0Data_r,
                                           beat0Bws_r);
            mem_nxt[wbAddr_r ^ 4'h1] = mergeLanes(mem_r[wbAddr_r ^ 4'h1],
                                           beat1Data_r, beat1Bws_r);
            wrTgl_nxt = ~wrTgl_r;
        end
        // load high starts nothing, select ignored
        if (!cmd.loadN)
        begin
            op_nxt     = cmd.readSel ? bts_pkg::BTS_READ : bts_pkg::BTS_WRITE;
            opAddr_nxt = cmd.addr;
        end
        case (op_r)
            bts_pkg::BTS_WRITE:
            begin
                beat0Taken_nxt = 1'b1;
                beat0Data_nxt  = dqIn;
                beat0Bws_nxt   = byte_write_select_n;
                wbAddr_nxt     = opAddr_r;
            end
            bts_pkg::BTS_READ:
            begin
                // read-through of a commit on this same edge
                rdLive_nxt  = 1'b1;
                rdWord0_nxt = mem_nxt[opAddr_r];
                rdWord1_nxt = mem_nxt[opAddr_r ^ 4'h1];
            end
            default:
            begin
                rdLive_nxt = 1'b0;
            end
        endcase
        posData_nxt  = rdLive_r ? rdWord1_r : posData_r;
        posOe_nxt    = rdLive_r; // release after last rise
        busyLink_nxt = rdLive_r || beat0Taken_r || posOe_r ||
                       op_r != bts_pkg::BTS_IDLE;
    end

    always_ff @(posedge kClk)
    begin
        if (!linkRstN)
        begin
            for (int i = 0; i < bts_pkg::DEPTH; i++)
                mem_r[i] <= bts_pkg::DATA_RST;
            op_r         <= bts_pkg::BTS_IDLE;
            opAddr_r     <= bts_pkg::ADDR_RST;
            wbAddr_r     <= bts_pkg::ADDR_RST;
            beat0Taken_r <= 1'b0;
            beat0Data_r  <= bts_pkg::DATA_RST;
            beat0Bws_r   <= bts_pkg::BWS_RST;
            rdLive_r     <= 1'b0;
            rdWord0_r    <= bts_pkg::DATA_RST;
            rdWord1_r    <= bts_pkg::DATA_RST;
            posData_r    <= bts_pkg::DATA_RST;
            posOe_r      <= 1'b0; // deselected at start
            strapDone_r  <= 1'b0;
            singleClk_r  <= 1'b0;
            wrTgl_r      <= 1'b0;
            busyLink_r   <= 1'b0;
        end
        else
        begin
            mem_r        <= mem_nxt;
            op_r         <= op_nxt;
            opAddr_r     <= opAddr_nxt;
            wbAddr_r     <= wbAddr_nxt;
            beat0Taken_r <= beat0Taken_nxt;
            beat0Data_r  <= beat0Data_nxt;
            beat0Bws_r   <= beat0Bws_nxt;
            rdLive_r     <= rdLive_nxt;
            rdWord0_r    <= rdWord0_nxt;
            rdWord1_r    <= rdWord1_nxt;
            posData_r    <= posData_nxt;
            posOe_r      <= posOe_nxt;
            strapDone_r  <= strapDone_nxt;
            singleClk_r  <= singleClk_nxt;
            wrTgl_r      <= wrTgl_nxt;
            busyLink_r   <= busyLink_nxt;
        end
    end

    // ********************************************************
    // falling-edge link state
    // ********************************************************
    logic [bts_pkg::DATA_W-1:0] negData_r, negData_nxt;
    logic                       negOe_r, negOe_nxt;
    logic [bts_pkg::DATA_W-1:0] beat1Data_nxt;
    logic [bts_pkg::LANES-1:0]  beat1Bws_nxt;

    always_comb
    begin
        beat1Data_nxt = beat0Taken_r ? dqIn : beat1Data_r;
        beat1Bws_nxt  = beat0Taken_r ? byte_write_select_n
                                     : beat1Bws_r;
        // otherwise hold the rising beat through the low phase
        negData_nxt   = rdLive_r ? rdWord0_r : posData_r;
        negOe_nxt     = rdLive_r || posOe_r;
    end

    always_ff @(negedge kClk)
    begin
        if (!linkRstN)
        begin
            beat1Data_r <= bts_pkg::DATA_RST;
            beat1Bws_r  <= bts_pkg::BWS_RST;
            negData_r   <= bts_pkg::DATA_RST;
            negOe_r     <= 1'b0;
        end
        else
        begin
            beat1Data_r <= beat1Data_nxt;
            beat1Bws_r  <= beat1Bws_nxt;
            negData_r   <= negData_nxt;
            negOe_r     <= negOe_nxt;
        end
    end

    // ddr launch: each phase shows its own edge flop
    // a stopped clock freezes both the flops and the select
    assign dqOut = kClk ? posData_r : negData_r;
    assign dqOe  = kClk ? posOe_r : negOe_r;

    // ********************************************************
    // system side status
    // ********************************************************
    logic [2:0] statSync;
    logic       tglSeen_r, tglSeen_nxt;
    logic       single_nxt, busy_nxt, stb_nxt;

    bts_sync #(.W(3)) uStatSync (
        .dstClk  (sys_clk),
        .asyncIn ({singleClk_r, busyLink_r, wrTgl_r}),
        .syncOut (statSync)
    );

    always_comb
    begin
        single_nxt  = statSync[2];
        busy_nxt    = statSync[1];
        tglSeen_nxt = statSync[0];
        stb_nxt     = statSync[0] ^ tglSeen_r;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            singleClkMode <= 1'b0;
            linkBusy      <= 1'b0;
            tglSeen_r     <= 1'b0;
            writeDoneStb  <= 1'b0;
        end
        else
        begin
            singleClkMode <= single_nxt;
            linkBusy      <= busy_nxt;
            tglSeen_r     <= tglSeen_nxt;
            writeDoneStb  <= stb_nxt;
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    sequence seqReadStart;
        !cmd.loadN && cmd.readSel;
    endsequence

    sequence seqWriteStart;
        !cmd.loadN && !cmd.readSel;
    endsequence

    chk_read_fetch: assert property (
        @(posedge kClk) disable iff (!linkRstN)
        seqReadStart |=> ##1 rdLive_r ##1
            (posOe_r && posData_r == $past(rdWord1_r)))
        else $error("read word not launched at t+2");

    chk_read_word0: assert property (
        @(negedge kClk) disable iff (!linkRstN)
        rdLive_r |=> negOe_r && negData_r == $past(rdWord0_r))
        else $error("first read word missing on falling edge");

    chk_write_beat: assert property (
        @(posedge kClk) disable iff (!linkRstN)
        seqWriteStart |=> ##1 beat0Taken_r && beat0Data_r == $past(dqIn))
        else $error("write beat not taken at t+1");

    chk_addr_latch: assert property (
        @(posedge kClk) disable iff (!linkRstN)
        seqWriteStart |=> ##1 wbAddr_r == $past(cmd.addr, 2))
        else $error("write address not latched at start");

    chk_nop_idle: assert property (
        @(posedge kClk) disable iff (!linkRstN)
        cmd.loadN |=> op_r == bts_pkg::BTS_IDLE ##1 !beat0Taken_r && !rdLive_r)
        else $error("operation started while load high");

    chk_power_up: assert property (
        @(posedge kClk)
        !linkRstN |=> !posOe_r)
        else $error("outputs driven after reset");

    chk_release_z: assert property (
        @(posedge kClk) disable iff (!linkRstN)
        posOe_r && !rdLive_r |=> !posOe_r)
        else $error("outputs not released after last read");

    chk_mask_keep: assert property (
        @(posedge kClk) disable iff (!linkRstN)
        beat0Taken_r && (&beat0Bws_r) && beat1Bws_r != bts_pkg::BWS_RST
        |=> mem_r[$past(wbAddr_r)] == $past(mem_r[wbAddr_r]))
        else $error("masked beat altered the array");

    chk_lane_write: assert property (
        @(posedge kClk) disable iff (!linkRstN)
        beat0Taken_r && !beat0Bws_r[0]
        |=> mem_r[$past(wbAddr_r)][8:0] == $past(beat0Data_r[8:0]))
        else $error("selected low lane not written");

endmodule

// >>> tb/bts_ctrl_model.sv
// controller model driving the burst-of-two sram port link
// assumes the port samples commands on kClk rise, data on rise and fall
`timescale 1ns/1ps
module bts_ctrl_model (
    output logic                           kClk,
    output logic                           load_strobe_n,
    output logic                           readNotWrite,
    output logic [bts_pkg::ADDR_W-1:0]     addrIn,
    output logic [bts_pkg::DATA_W-1:0]     dqIn,
    output logic [bts_pkg::LANES-1:0]      byte_write_select_n
);
    // two write stages: beat0 goes out one call late, beat1 two calls late
    logic                       pend0, pend1;
    logic [bts_pkg::DATA_W-1:0] w0, w1, pd1;
    logic [bts_pkg::LANES-1:0]  ws0, ws1, ps1;
    // ********
    // link clock
    // ********
    // free running: the port needs kClk during reset
    initial
    begin
        kClk = 1'b0;
        load_strobe_n = 1'b1;
        readNotWrite = 1'b0;
        addrIn = 4'h0;
        dqIn = 36'h0_0000_0000;
        byte_write_select_n = 4'hf;
        pend0 = 1'b0;
        pend1 = 1'b0;
        #3;
        forever #6 kClk = ~kClk;
    end
    // ********
    // one command per rise
    // ********
    // unused lines flip so stale values never look valid
    task automatic issue(
        input logic                       ld,
        input logic                       rw,
        input logic [bts_pkg::ADDR_W-1:0] a,
        input logic [bts_pkg::DATA_W-1:0] d0,
        input logic [bts_pkg::DATA_W-1:0] d1,
        input logic [bts_pkg::LANES-1:0]  s0,
        input logic [bts_pkg::LANES-1:0]  s1
    );
    begin
        @(posedge kClk);
        load_strobe_n <= ld;
        readNotWrite <= ld ? ~readNotWrite : rw;
        addrIn <= ld ? ~addrIn : a;
        dqIn <= pend1 ? pd1 : ~dqIn;
        byte_write_select_n <= pend1 ? ps1 : ~byte_write_select_n;
        @(negedge kClk);
        dqIn <= pend0 ? w0 : ~dqIn;
        byte_write_select_n <= pend0 ? ws0 : ~byte_write_select_n;
        pend1 = pend0;
        pd1 = w1;
        ps1 = ws1;
        pend0 = !ld && !rw;
        w0 = d0;
        w1 = d1;
        ws0 = s0;
        ws1 = s1;
    end
    endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench: 36-bit and 18-bit ports behind one controller
// assumes both ports see the same link traffic
`timescale 1ns/1ps
module tb_top;
    typedef logic [bts_pkg::DATA_W-1:0] bts_word_t;
    typedef struct packed {
        logic [3:0] a;
        bts_word_t  d0;
        bts_word_t  d1;
        logic [3:0] s0;
        logic [3:0] s1;
    } bts_row_t;
    localparam bts_word_t NMASK = 36'h0_0003_ffff;
    logic sys_clk = 1'b0, rst_n = 1'b0, strap = 1'b1;
    logic kClk, load_strobe_n, readNotWrite;
    logic [3:0] addrIn, byte_write_select_n;
    bts_word_t  dqIn, qA, qB, hiQ, hiN, loQ, loN;
    logic oeA, oeB, scA, scB, wdA, hiOe, loOe, busyA;
    bts_word_t  refA [16], refB [16];
    int errors = 0, comparisons = 0, nDone = 0, nW = 0;
    bts_row_t rows [6] = '{
        '{4'h2, 36'h1_2345_6789, 36'h9_8765_4321, 4'h0, 4'h0},
        '{4'h3, 36'ha_aaaa_aaaa, 36'h5_5555_5555, 4'he, 4'hd},
        '{4'h5, 36'hc_3c3c_3c3c, 36'h3_c3c3_c3c3, 4'hb, 4'h7},
        '{4'h4, 36'hf_0f0f_0f0f, 36'h0_f0f0_f0f0, 4'hf, 4'h0},
        '{4'h7, 36'h6_9696_9696, 36'h9_6969_6969, 4'h0, 4'hf},
        '{4'h3, 36'h7_7777_7777, 36'h8_8888_8888, 4'hc, 4'h3}};
    always #4 sys_clk = ~sys_clk;
    bts_ctrl_model i_bts_ctrl_model (.kClk, .load_strobe_n,
        .readNotWrite, .addrIn, .dqIn, .byte_write_select_n);
    bts_sram_port #(.WIDE36(1'b1)) i_bts_sram_port (.sys_clk, .rst_n,
        .kClk, .load_strobe_n, .readNotWrite, .addrIn, .dqIn,
        .byte_write_select_n, .outClkPosPin(strap), .outClkNegPin(strap),
        .dqOut(qA), .dqOe(oeA), .singleClkMode(scA), .linkBusy(busyA),
        .writeDoneStb(wdA));
    bts_sram_port #(.WIDE36(1'b0)) i_bts_sram_port18 (.sys_clk, .rst_n,
        .kClk, .load_strobe_n, .readNotWrite, .addrIn, .dqIn,
        .byte_write_select_n, .outClkPosPin(1'b0), .outClkNegPin(1'b0),
        .dqOut(qB), .dqOe(oeB), .singleClkMode(scB), .linkBusy(),
        .writeDoneStb());
    // ********
    // observers, mid phase of kClk
    // ********
    always @(posedge kClk)
    begin
        #3;
        {hiQ, hiN, hiOe} = {qA, qB, oeA};
    end
    always @(negedge kClk)
    begin
        #3;
        {loQ, loN, loOe} = {qA, qB, oeA};
    end
    always @(posedge sys_clk)
        if (wdA === 1'b1) nDone++;
    task automatic cmpw(input bts_word_t g, input bts_word_t e);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH at %0t: word %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp1(input logic g, input logic e);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH at %0t: flag %b expected %b", $time, g, e);
        end
    endtask
    task automatic chkw(input bts_word_t q, input bts_word_t n,
                        input logic oe, input logic [3:0] a);
        cmpw(q, refA[a]);
        cmpw(n & NMASK, refB[a] & NMASK);
        cmp1(oe, 1'b1);
    endtask
    task automatic nop;
        i_bts_ctrl_model.issue(1'b1, 1'b0, 4'h0, '0, '0, 4'h0, 4'h0);
    endtask
    task automatic wr(input bts_row_t r);
        i_bts_ctrl_model.issue(1'b0, 1'b0, r.a, r.d0, r.d1, r.s0, r.s1);
        nW++;
        for (int l = 0; l < 4; l++)
        begin
            if (!r.s0[l]) refA[r.a][l*9 +: 9] = r.d0[l*9 +: 9];
            if (!r.s1[l]) refA[r.a ^ 4'h1][l*9 +: 9] = r.d1[l*9 +: 9];
            if (l < 2 && !r.s0[l]) refB[r.a][l*9 +: 9] = r.d0[l*9 +: 9];
            if (l < 2 && !r.s1[l])
                refB[r.a ^ 4'h1][l*9 +: 9] = r.d1[l*9 +: 9];
        end
    endtask
    // reads a, and b on the next rise if two; a nop always follows
    task automatic rd2(input logic [3:0] a, input logic [3:0] b,
                       input logic two);
        i_bts_ctrl_model.issue(1'b0, 1'b1, a, '0, '0, 4'h0, 4'h0);
        i_bts_ctrl_model.issue(!two, 1'b1, b, '0, '0, 4'h0, 4'h0);
        nop();
        #4 chkw(loQ, loN, loOe, a);
        nop();
        chkw(hiQ, hiN, hiOe, a ^ 4'h1);
        if (two)
        begin
            #4 chkw(loQ, loN, loOe, b);
            nop();
            chkw(hiQ, hiN, hiOe, b ^ 4'h1);
        end
        nop();
        cmp1(hiOe, 1'b0);
    endtask
    task automatic endtest(input string s);
        $display("test %s done, %0d mismatches", s, errors);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic do_reset;
        foreach (refA[i]) {refA[i], refB[i]} = '0;
        @(posedge sys_clk) rst_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        cmpw(qA, '0);
        cmp1(oeA, 1'b0);
        rst_n <= 1'b1;
        repeat (8) @(posedge kClk);
        cmp1(oeA, 1'b0);
        cmp1(busyA, 1'b0);
    endtask
    initial
    begin
        #20000;
        errors++;
        report_and_stop();
    end
    initial
    begin
        do_reset();
        cmp1(scA, 1'b1);
        cmp1(scB, 1'b0);
        endtest("reset");
        foreach (rows[i])
        begin
            wr(rows[i]);
            nop();
            rd2(rows[i].a, 4'h0, 1'b0);
        end
        endtest("rows");
        wr('{4'h9, 36'h1_1111_1111, 36'h2_2222_2222, 4'h0, 4'h0});
        rd2(4'h9, 4'h0, 1'b0);
        endtest("bypass");
        wr('{4'ha, 36'h3_3333_3333, 36'h4_4444_4444, 4'h0, 4'h0});
        wr('{4'hb, 36'h5_5555_5555, 36'h6_6666_6666, 4'h5, 4'ha});
        nop();
        rd2(4'ha, 4'hb, 1'b1);
        endtest("back to back");
        repeat (10) @(posedge sys_clk);
        cmp1(nDone == nW, 1'b1);
        do_reset();
        rd2(4'h2, 4'h0, 1'b0);
        endtest("mid reset");
        report_and_stop();
    end
endmodule
